// ---- hdl/rcs_sequencer.v ----
// Receiver gain loop, carrier sense and automatic wake-up sequencer with APB registers
//
// Design decisions made here: the APB register port and the register offsets.
`include "rcs_map.vh"
module rcs_sequencer (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [7:0]  rxMagnitude,
  input  wire [7:0]  freqOffsetIn,
  input  wire [7:0]  instFreqIn,
  input  wire        pllUnlocked,
  input  wire        freqSetSwitch,
  input  wire        calDone,
  input  wire        selectPin,
  input  wire        dataIoPin,
  output reg  [4:0]  vgaGain,
  output reg         rxPowerOn,
  output reg         calStart,
  output reg         statusPin,
  output reg         txGaussEnable,
  output reg  [7:0]  txOutputLevel,
  output reg         demodClock
);
  localparam [2:0] G_OFF  = 3'h0;
  localparam [2:0] G_HOLD = 3'h1;
  localparam [2:0] G_WAIT = 3'h2;
  localparam [2:0] G_AVG  = 3'h3;
  localparam [2:0] G_DEC  = 3'h4;
  localparam [2:0] S_SLEEP = 3'h0;
  localparam [2:0] S_CAL   = 3'h1;
  localparam [2:0] S_SETTL = 3'h2;
  localparam [2:0] S_CHECK = 3'h3;
  localparam [2:0] S_AWAKE = 3'h4;
  localparam [2:0] S_IDLE  = 3'h5;

  reg [7:0]  mainReg_r;
  reg [8:0]  seqReg_r;
  reg [4:0]  gainTimingReg_r;
  reg [1:0]  gainAverageReg_r;
  reg [7:0]  gainLimitReg_r;
  reg [7:0]  senseLevelReg_r;
  reg [3:0]  pinSelect_r;
  reg [23:0] clkDiv_r;
  reg [7:0]  freqOffsetAverage_r;
  reg [7:0]  instantFreqSample_r;
  reg [7:0]  strength_r;
  reg        carrier_r;

  wire       seqMode = (mainReg_r[1:0] == `RCS_PD_AUTO);
  wire       wr = psel & penable & pwrite;

  // APB decode, zero-wait
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mainReg_r        <= `RCS_RST_MAIN;
      seqReg_r         <= `RCS_RST_SEQ;
      gainTimingReg_r  <= `RCS_RST_GTIME;
      gainAverageReg_r <= `RCS_RST_GAVG;
      gainLimitReg_r   <= `RCS_RST_GLIM;
      senseLevelReg_r  <= `RCS_RST_SENSE;
      pinSelect_r      <= 4'h0;
      txGaussEnable    <= 1'b0;
      txOutputLevel    <= `RCS_RST_TXLVL;
      clkDiv_r         <= `RCS_RST_CLKDIV;
    end else if (wr) begin
      if (hit(paddr, `RCS_OFF_MAIN))      mainReg_r        <= pwdata[7:0];
      if (hit(paddr, `RCS_OFF_SEQ))       seqReg_r         <= pwdata[8:0];
      if (hit(paddr, `RCS_OFF_GTIME))     gainTimingReg_r  <= pwdata[4:0];
      if (hit(paddr, `RCS_OFF_GAVG))      gainAverageReg_r <= pwdata[1:0];
      if (hit(paddr, `RCS_OFF_GLIM))      gainLimitReg_r   <= pwdata[7:0];
      if (hit(paddr, `RCS_OFF_SENSE))     senseLevelReg_r  <= pwdata[7:0];
      if (hit(paddr, `RCS_OFF_STATUSPIN)) pinSelect_r      <= pwdata[3:0];
      if (hit(paddr, `RCS_OFF_DEVCTL))    txGaussEnable    <= pwdata[0];
      if (hit(paddr, `RCS_OFF_TXLVL))     txOutputLevel    <= pwdata[7:0];
      if (hit(paddr, `RCS_OFF_CLKDIV))    clkDiv_r         <= pwdata[23:0];
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `RCS_OFF_MAIN:      prdata[7:0]  = mainReg_r;
      `RCS_OFF_SEQ:       prdata[8:0]  = seqReg_r;
      `RCS_OFF_GTIME:     prdata[4:0]  = gainTimingReg_r;
      `RCS_OFF_GAVG:      prdata[1:0]  = gainAverageReg_r;
      `RCS_OFF_GLIM:      prdata[7:0]  = gainLimitReg_r;
      `RCS_OFF_SENSE:     prdata[7:0]  = senseLevelReg_r;
      `RCS_OFF_STATUSPIN: prdata[3:0]  = pinSelect_r;
      `RCS_OFF_STATUS:    prdata[`RCS_STATUS_CS_BIT] = carrier_r;
      `RCS_OFF_AFC:       prdata[7:0]  = freqOffsetAverage_r;
      `RCS_OFF_IFS:       prdata[7:0]  = instantFreqSample_r;
      `RCS_OFF_DEVCTL:    prdata[0]    = txGaussEnable;
      `RCS_OFF_TXLVL:     prdata[7:0]  = txOutputLevel;
      `RCS_OFF_CLKDIV:    prdata[23:0] = clkDiv_r;
      `RCS_OFF_STRENGTH:  prdata[7:0]  = strength_r;
      default:            prdata       = 32'h0000_0000;
    endcase
  end

  // Tick dividers: ADC div [2:0] in two-cycle steps, filter div [10:3], demod div [23:11] in sys cycles
  reg [3:0]  adcCnt_r;
  reg [7:0]  filtCnt_r;
  reg [12:0] demodCnt_r;
  wire [3:0] adcLimit = {clkDiv_r[2:0], 1'b1};
  wire adcTick   = (adcCnt_r == adcLimit);
  wire filtTick  = (filtCnt_r == clkDiv_r[10:3]);
  wire demodTick = (demodCnt_r == clkDiv_r[23:11]);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adcCnt_r   <= 4'h0;
      filtCnt_r  <= 8'h00;
      demodCnt_r <= 13'h0000;
      demodClock <= 1'b0;
    end else begin
      adcCnt_r   <= adcTick ? 4'h0 : adcCnt_r + 4'h1;
      filtCnt_r  <= filtTick ? 8'h00 : filtCnt_r + 8'h01;
      demodCnt_r <= demodTick ? 13'h0000 : demodCnt_r + 13'h0001;
      if (demodTick) demodClock <= ~demodClock;
    end
  end
  wire demodRise = demodTick & ~demodClock;

  // Pin synchronisers: three stages, edge once stages two and three agree
  reg [2:0] selSync_r;
  reg [2:0] dataSync_r;
  reg       selLvl_r;
  reg       dataLvl_r;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      selSync_r  <= 3'h7;
      dataSync_r <= 3'h7;
      selLvl_r   <= 1'b1;
      dataLvl_r  <= 1'b1;
    end else begin
      selSync_r  <= {selSync_r[1:0], selectPin};
      dataSync_r <= {dataSync_r[1:0], dataIoPin};
      if (selSync_r[1] == selSync_r[2]) selLvl_r <= selSync_r[2];
      if (dataSync_r[1] == dataSync_r[2]) dataLvl_r <= dataSync_r[2];
    end
  end
  wire selFall  = selLvl_r & (selSync_r[1] == selSync_r[2]) & ~selSync_r[2];
  wire dataFall = dataLvl_r & (dataSync_r[1] == dataSync_r[2]) & ~dataSync_r[2];
  wire wakeEdge = seqReg_r[`RCS_SEQ_SELWAKE] ? selFall
                : (seqReg_r[`RCS_SEQ_SPLIT] & dataFall);

  // Gain loop
  reg [2:0]  sState_r;
  reg [2:0]  gState_r;
  reg [6:0]  gCnt_r;
  reg [11:0] accum_r;
  reg        rxOnDly_r;
  reg        unlockDly_r;
  reg        setDly_r;
  // Hold doubles per step up to 128 ticks; wait saturates at three steps of 16
  wire [7:0] holdLen  = (`RCS_HOLD_BASE << gainTimingReg_r[1:0]) - 8'h01;
  wire [1:0] waitSel  = (gainTimingReg_r[4:3] != 2'h0) ? 2'h2 : {1'b0, gainTimingReg_r[2]};
  wire [6:0] waitLen  = `RCS_WAIT_BASE * ({5'h00, waitSel} + 7'h01);
  wire [4:0] avgLen   = 5'h02 << gainAverageReg_r;
  wire [11:0] avgFull = accum_r >> ({1'b0, gainAverageReg_r} + 3'h1);
  wire [7:0] avgValue = avgFull[7:0];
  wire [8:0] csLimit  = {4'h0, senseLevelReg_r[4:0]} + `RCS_CS_MARGIN;
  wire [8:0] upLimit  = {4'h0, senseLevelReg_r[4:0]} - {6'h00, senseLevelReg_r[7:5]};
  wire [8:0] dnLimit  = csLimit + {6'h00, gainLimitReg_r[7:5]};
  wire       rxOn     = seqMode ? (sState_r == S_SETTL || sState_r == S_CHECK ||
                                   sState_r == S_AWAKE) : mainReg_r[`RCS_MAIN_RXON_BIT];
  wire       reHold   = rxOn & ((rxOn & ~rxOnDly_r) | (pllUnlocked & ~unlockDly_r)
                                | (freqSetSwitch != setDly_r));

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gState_r    <= G_OFF;
      gCnt_r      <= 7'h00;
      accum_r     <= 12'h000;
      strength_r  <= 8'h00;
      carrier_r   <= 1'b0;
      vgaGain     <= 5'h00;
      rxOnDly_r   <= 1'b0;
      unlockDly_r <= 1'b0;
      setDly_r    <= 1'b0;
    end else begin
      rxOnDly_r   <= rxOn;
      unlockDly_r <= pllUnlocked;
      setDly_r    <= freqSetSwitch;
      if (!rxOn) begin
        gState_r  <= G_OFF;
        carrier_r <= 1'b0;
      end else if (reHold) begin
        gState_r <= G_HOLD;
        gCnt_r   <= 7'h00;
      end else begin
        case (gState_r)
          G_HOLD: if (adcTick) begin
            if (gCnt_r == holdLen[6:0]) begin
              gState_r <= G_WAIT;
              gCnt_r   <= 7'h00;
            end else gCnt_r <= gCnt_r + 7'h01;
          end
          G_WAIT: if (filtTick) begin
            if (gCnt_r == waitLen - 7'h01) begin
              gState_r <= G_AVG;
              gCnt_r   <= 7'h00;
              accum_r  <= 12'h000;
            end else gCnt_r <= gCnt_r + 7'h01;
          end
          G_AVG: if (filtTick) begin
            accum_r <= accum_r + {4'h0, rxMagnitude};
            if (gCnt_r == {2'h0, avgLen} - 7'h01) gState_r <= G_DEC;
            else gCnt_r <= gCnt_r + 7'h01;
          end
          G_DEC: begin
            strength_r <= avgValue;
            accum_r    <= 12'h000;
            carrier_r  <= ({1'b0, avgValue} > csLimit) & ~gainLimitReg_r[4] ? 1'b1 : 1'b0;
            gCnt_r     <= 7'h00;
            gState_r   <= G_WAIT;
            if ({1'b0, avgValue} > dnLimit && vgaGain != 5'h00)
              vgaGain <= vgaGain - 5'h01;
            else if ({1'b0, avgValue} < upLimit && vgaGain < gainLimitReg_r[4:0])
              vgaGain <= vgaGain + 5'h01;
            else
              gState_r <= G_AVG;
          end
          default: begin
            gState_r <= G_HOLD;
            gCnt_r   <= 7'h00;
          end
        endcase
      end
    end
  end

  // Wake-up sequencer
  reg [10:0] seqCnt_r;
  reg [7:0]  seqNum_r;
  wire [10:0] settleLen = `RCS_SEQ_STEP * ({8'h00, seqReg_r[2:0]} + 11'h001);
  wire [10:0] checkLen  = `RCS_SEQ_STEP * ({7'h00, seqReg_r[6:3]} + 11'h001);
  reg         calDue;
  always @* begin
    case (mainReg_r[5:4])
      2'h0:    calDue = 1'b1;
      2'h1:    calDue = (seqNum_r[3:0] == 4'h0);
      2'h2:    calDue = (seqNum_r == 8'h00);
      default: calDue = 1'b0;
    endcase
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sState_r <= S_IDLE;
      seqCnt_r <= 11'h000;
      seqNum_r <= 8'h00;
      calStart <= 1'b0;
    end else begin
      calStart <= 1'b0;
      if (!seqMode) sState_r <= S_IDLE;
      else case (sState_r)
        S_IDLE: if (mainReg_r[`RCS_MAIN_SLEEP_BIT]) sState_r <= S_SLEEP;
        S_SLEEP: if (wakeEdge) begin
          seqCnt_r <= 11'h000;
          seqNum_r <= seqNum_r + 8'h01;
          if (calDue) begin
            calStart <= 1'b1;
            sState_r <= S_CAL;
          end else sState_r <= S_SETTL;
        end
        S_CAL: if (calDone) sState_r <= S_SETTL;
        S_SETTL: begin
          seqCnt_r <= seqCnt_r + 11'h001;
          if (seqCnt_r == settleLen) begin
            seqCnt_r <= 11'h000;
            sState_r <= S_CHECK;
          end
        end
        S_CHECK: begin
          seqCnt_r <= seqCnt_r + 11'h001;
          if (carrier_r) sState_r <= S_AWAKE;
          else if (seqCnt_r == checkLen) sState_r <= S_SLEEP;
        end
        S_AWAKE: if (mainReg_r[`RCS_MAIN_SLEEP_BIT] && wr && hit(paddr, `RCS_OFF_MAIN))
          sState_r <= S_SLEEP;
        default: sState_r <= S_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxPowerOn           <= 1'b0;
      statusPin           <= 1'b0;
      freqOffsetAverage_r <= 8'h00;
      instantFreqSample_r <= 8'h00;
    end else begin
      rxPowerOn           <= rxOn;
      freqOffsetAverage_r <= freqOffsetIn;
      if (demodRise) instantFreqSample_r <= instFreqIn;
      case (pinSelect_r)
        `RCS_PIN_CARRIER: statusPin <= carrier_r;
        `RCS_PIN_DEMOD:   statusPin <= demodClock;
        default:          statusPin <= 1'b0;
      endcase
    end
  end
endmodule // rcs_sequencer

// ---- hdl/rcs_map.vh ----
// Register map, field positions, reset values and timing counts of the receiver sequencer
`ifndef RCS_MAP_VH
`define RCS_MAP_VH
`define RCS_OFF_MAIN       12'h000
`define RCS_OFF_SEQ        12'h004
`define RCS_OFF_GTIME      12'h008
`define RCS_OFF_GAVG       12'h00C
`define RCS_OFF_GLIM       12'h010
`define RCS_OFF_SENSE      12'h014
`define RCS_OFF_STATUSPIN  12'h018
`define RCS_OFF_STATUS     12'h01C
`define RCS_OFF_AFC        12'h020
`define RCS_OFF_IFS        12'h024
`define RCS_OFF_DEVCTL     12'h028
`define RCS_OFF_TXLVL      12'h02C
`define RCS_OFF_CLKDIV     12'h030
`define RCS_OFF_STRENGTH   12'h034
// MAIN: powerdown_style [1:0], in sequencing mode auto_sleep_request [2], auto_cal_interval [5:4]
`define RCS_MAIN_PD_LSB    0
`define RCS_MAIN_SLEEP_BIT 2
`define RCS_MAIN_CAL_LSB   4
`define RCS_MAIN_RXON_BIT  3
// SEQ: settle [2:0], carrier check [6:3], wake_from_select [7], split_data_pins [8]
`define RCS_SEQ_SELWAKE    7
`define RCS_SEQ_SPLIT      8
`define RCS_STATUS_CS_BIT  3
`define RCS_PD_AUTO        2'h3
`define RCS_PIN_CARRIER    4'h4
`define RCS_PIN_DEMOD      4'hD
`define RCS_RST_MAIN       8'h00
`define RCS_RST_SEQ        9'h000
`define RCS_RST_GTIME      5'h00
`define RCS_RST_GAVG       2'h0
`define RCS_RST_GLIM       8'h1F
`define RCS_RST_SENSE      8'h00
`define RCS_RST_TXLVL      8'h0F
`define RCS_RST_CLKDIV     24'h00_0001
`define RCS_HOLD_BASE      8'h10
`define RCS_WAIT_BASE      7'h10
`define RCS_CS_MARGIN      9'h008
`define RCS_SEQ_STEP       11'h040
`endif

// ---- testbench/rcs_sequencer_props.sv ----
// Port-level assertions for the receiver sequencer
`include "rcs_map.vh"
module rcs_sequencer_props (
  input wire        clk_sys,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [4:0]  vgaGain,
  input wire        rxPowerOn,
  input wire        calStart,
  input wire        statusPin,
  input wire [7:0]  txOutputLevel,
  input wire        demodClock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire      wr = psel && penable && pwrite;
  reg [3:0] pinSrc_r;
  reg       rxOn_r;
  reg [4:0] lim_r;
  // Shadow of the writable fields that the checks depend on
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinSrc_r <= 4'h0;
      rxOn_r   <= 1'b0;
      lim_r    <= 5'h1F;
    end else if (wr) begin
      if (paddr == `RCS_OFF_STATUSPIN) pinSrc_r <= pwdata[3:0];
      if (paddr == `RCS_OFF_MAIN) rxOn_r <= pwdata[`RCS_MAIN_RXON_BIT];
      if (paddr == `RCS_OFF_GLIM) lim_r <= pwdata[4:0];
    end
  end
  a_level_write: assert property (
    wr && paddr == `RCS_OFF_TXLVL |=> txOutputLevel == $past(pwdata[7:0]))
    else $error("output level not taken");
  a_demod_pin: assert property (
    pinSrc_r == `RCS_PIN_DEMOD && $past(pinSrc_r) == `RCS_PIN_DEMOD && $rose(demodClock)
    |-> ##[0:2] statusPin) else $error("demod clock missing on pin");
  a_cal_pulse: assert property (
    calStart |=> !calStart) else $error("calibration start longer than one cycle");
  a_rx_manual: assert property (
    wr && paddr == `RCS_OFF_MAIN && pwdata[1:0] != `RCS_PD_AUTO
    |=> ##[0:1] rxPowerOn == rxOn_r) else $error("receiver enable not followed");
  a_sleep_req: assert property (
    wr && paddr == `RCS_OFF_MAIN && pwdata[1:0] == `RCS_PD_AUTO
    && pwdata[`RCS_MAIN_SLEEP_BIT] |-> ##[1:3] !rxPowerOn) else $error("no power-down");
  a_gain_hold: assert property (
    $rose(rxPowerOn) |-> ##2 $stable(vgaGain) [*8]) else $error("gain moved during hold");
  a_gain_step: assert property (
    rxPowerOn && $past(rxPowerOn, 3) && $changed(vgaGain) |->
    vgaGain == $past(vgaGain) + 5'h01 || vgaGain == $past(vgaGain) - 5'h01)
    else $error("gain jumped");
  a_gain_limit: assert property (
    rxPowerOn |-> vgaGain <= lim_r) else $error("gain above maximum");
endmodule // rcs_sequencer_props

// ---- testbench/rcs_host_pins.sv ----
// Host-side model of the select and data wake pins
module rcs_host_pins (
  input  wire  clk_sys,
  input  wire  wakeSel,
  input  wire  wakeData,
  output logic selectPin,
  output logic dataIoPin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] selCnt_r = 4'h0;
  logic [3:0] datCnt_r = 4'h0;
  // Pins idle high; a request pulls the pin low for eight cycles
  always @(posedge clk_sys) begin
    selCnt_r <= wakeSel ? 4'h8 : selCnt_r - (selCnt_r != 4'h0);
    datCnt_r <= wakeData ? 4'h8 : datCnt_r - (datCnt_r != 4'h0);
  end
  assign selectPin = selCnt_r == 4'h0;
  assign dataIoPin = datCnt_r == 4'h0;
endmodule // rcs_host_pins

// ---- testbench/rcs_sequencer_bench.sv ----
// Self-checking bench for the receiver sequencer
`include "rcs_map.vh"
module rcs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0]  rxMagnitude = 8'h00, freqOffsetIn = 8'h00, instFreqIn = 8'h00;
  logic        freqSetSwitch = 1'b0, calDone = 1'b0, pllUnlocked = 1'b0;
  logic        wakeSel = 1'b0, wakeData = 1'b0;
  wire         pready, pslverr, selectPin, dataIoPin, rxPowerOn, calStart;
  wire         statusPin, txGaussEnable, demodClock;
  wire [31:0]  prdata;
  wire [4:0]   vgaGain;
  wire [7:0]   txOutputLevel;
  int          num_errors = 0, samples_checked = 0, cycles = 0, calCount = 0, d0, d1;
  always #5 clk_sys = ~clk_sys;
  // Calibration completes one cycle after it starts
  always @(posedge clk_sys) begin
    calDone <= calStart;
    if (calStart === 1'b1) calCount <= calCount + 1;
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      stop_test;
    end
  end
  rcs_sequencer uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rxMagnitude(rxMagnitude), .freqOffsetIn(freqOffsetIn),
    .instFreqIn(instFreqIn), .pllUnlocked(pllUnlocked), .freqSetSwitch(freqSetSwitch),
    .calDone(calDone), .selectPin(selectPin), .dataIoPin(dataIoPin), .vgaGain(vgaGain),
    .rxPowerOn(rxPowerOn), .calStart(calStart), .statusPin(statusPin),
    .txGaussEnable(txGaussEnable), .txOutputLevel(txOutputLevel), .demodClock(demodClock));
  rcs_host_pins host (.clk_sys(clk_sys), .wakeSel(wakeSel), .wakeData(wakeData),
    .selectPin(selectPin), .dataIoPin(dataIoPin));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic probe(int s, logic [4:0] g);
    return s == 0 ? demodClock : s == 1 ? rxPowerOn : vgaGain == g;
  endfunction
  task automatic waitFor(int s, logic v, logic [4:0] g = 5'h00);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (probe(s, g) !== v && n < 6000);
  endtask
  task automatic carrier(input logic e);
    apb(1'b0, `RCS_OFF_STATUS, 32'h0);
    chk("carrier bit", e, rd[`RCS_STATUS_CS_BIT]);
    chk("carrier pin", e, statusPin);
  endtask
  task automatic t_regs;
    apb(1'b0, `RCS_OFF_TXLVL, 32'h0);
    chk("level reset", 32'h0F, rd);
    apb(1'b1, `RCS_OFF_TXLVL, 32'hA5);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("level pin", 32'hA5, txOutputLevel);
    apb(1'b1, `RCS_OFF_DEVCTL, 32'h1);
    @(posedge clk_sys);
    chk("shaping", 32'h1, txGaussEnable);
    apb(1'b1, `RCS_OFF_CLKDIV, 32'h0000_2009);
    apb(1'b1, `RCS_OFF_STATUSPIN, {28'h0, `RCS_PIN_DEMOD});
    for (int v = 1; v >= 0; v--) begin
      waitFor(0, !v);
      waitFor(0, v);
      repeat (2) @(posedge clk_sys);
      chk("demod on pin", v, statusPin);
    end
    freqOffsetIn <= 8'h80;
    instFreqIn <= 8'h81;
    apb(1'b1, `RCS_OFF_AFC, 32'h11);
    apb(1'b0, `RCS_OFF_AFC, 32'h0);
    chk("avg offset", 32'h80, rd);
    waitFor(0, 1'b0);
    waitFor(0, 1'b1);
    apb(1'b0, `RCS_OFF_IFS, 32'h0);
    chk("instant offset", 32'h81, rd);
    // New sample must wait for the next demod clock rise
    instFreqIn <= 8'h7F;
    apb(1'b0, `RCS_OFF_IFS, 32'h0);
    chk("instant held", 32'h81, rd);
  endtask
  task automatic t_agc;
    logic [4:0] g0;
    apb(1'b1, `RCS_OFF_GTIME, 32'h0);
    apb(1'b1, `RCS_OFF_GAVG, 32'h0);
    apb(1'b1, `RCS_OFF_GLIM, 32'h06);
    apb(1'b1, `RCS_OFF_SENSE, 32'h24);
    apb(1'b1, `RCS_OFF_STATUSPIN, 32'h4);
    apb(1'b1, `RCS_OFF_MAIN, 32'h08);
    waitFor(1, 1'b1);
    repeat (2) @(posedge clk_sys);
    g0 = vgaGain;
    repeat (50) @(posedge clk_sys);
    chk("gain held", g0, vgaGain);
    waitFor(2, 1'b1, 5'h06);
    chk("gain at max", 32'h06, vgaGain);
    carrier(1'b0);
    rxMagnitude <= 8'h90;
    pllUnlocked <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("gain held on unlock", 32'h06, vgaGain);
    freqSetSwitch <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("gain held on switch", 32'h06, vgaGain);
    waitFor(2, 1'b1, 5'h00);
    chk("gain at min", 32'h00, vgaGain);
    apb(1'b0, `RCS_OFF_STRENGTH, 32'h0);
    chk("strength average", 32'h90, rd);
    carrier(1'b1);
    apb(1'b1, `RCS_OFF_GLIM, 32'h16);
    repeat (300) @(posedge clk_sys);
    carrier(1'b0);
    apb(1'b1, `RCS_OFF_MAIN, 32'h00);
  endtask
  task automatic wake(input logic bySel, input logic [31:0] seq, output int dur);
    apb(1'b1, `RCS_OFF_SEQ, seq);
    wakeSel <= bySel;
    wakeData <= !bySel;
    @(posedge clk_sys);
    wakeSel <= 1'b0;
    wakeData <= 1'b0;
    waitFor(1, 1'b1);
    chk("woken", 1, rxPowerOn);
    dur = 0;
    while (rxPowerOn === 1'b1 && dur < 6000) begin
      @(posedge clk_sys);
      dur++;
    end
    chk("asleep again", 0, rxPowerOn);
  endtask
  task automatic t_seq;
    int c0;
    rxMagnitude <= 8'h00;
    apb(1'b1, `RCS_OFF_MAIN, 32'h03);
    apb(1'b1, `RCS_OFF_MAIN, 32'h07);
    repeat (4) @(posedge clk_sys);
    chk("asleep", 0, rxPowerOn);
    c0 = calCount;
    wake(1'b1, 32'h180, d0);
    chk("cal every time", 1, calCount - c0);
    wakeData <= 1'b1;
    @(posedge clk_sys);
    wakeData <= 1'b0;
    repeat (50) @(posedge clk_sys);
    chk("data edge ignored", 0, rxPowerOn);
    wake(1'b0, 32'h118, d1);
    chk("check delay", 192, d1 - d0);
    apb(1'b1, `RCS_OFF_MAIN, 32'h37);
    c0 = calCount;
    wake(1'b1, 32'h180, d0);
    chk("cal never", 0, calCount - c0);
  endtask
  // Carrier found in the check phase keeps the receiver on until a sleep request
  task automatic t_awake;
    rxMagnitude <= 8'h90;
    apb(1'b1, `RCS_OFF_GLIM, 32'h0F);
    wakeSel <= 1'b1;
    @(posedge clk_sys);
    wakeSel <= 1'b0;
    waitFor(1, 1'b1);
    repeat (400) @(posedge clk_sys);
    chk("stays awake", 1, rxPowerOn);
    carrier(1'b1);
    apb(1'b1, `RCS_OFF_MAIN, 32'h37);
    repeat (3) @(posedge clk_sys);
    chk("sleep on request", 0, rxPowerOn);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_agc;
    t_seq;
    t_awake;
    stop_test;
  end
endmodule // rcs_sequencer_bench
bind rcs_sequencer rcs_sequencer_props chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .vgaGain(vgaGain),
  .rxPowerOn(rxPowerOn), .calStart(calStart), .statusPin(statusPin),
  .txOutputLevel(txOutputLevel), .demodClock(demodClock));
